// >>> hdl/gcsp_port.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [RULE1] Bit clock edges alone mark valid data; no frame sync used or made.
// [RULE2] The clock source stops the bit clock once the word is done.
// [RULE3] Only the transmit bit clock serves both directions, internal or external.
// [RULE4] Both enables off: idle. Receive only: external clock only.
// [RULE5] Transmit only: shift out on clocks, internal or external source.
// [RULE6] Both enables: transmit and receive on the same edges; the code shifts out on rising edges and captures on falling edges.
// [RULE7] Internal clock: bit, word, frame counters keep running; frame ignored.
// [RULE8] Internal clock: data write starts the clock at next word boundary.
// [RULE9] External clock: wait idle, shift as soon as edges arrive.
// [RULE10] Far party keeps the bit clock glitch free; no realignment exists.
// [RULE11] Each clock cycle shifts one bit out and captures one bit in.
// [RULE12] Internal clock idle time is a whole number of word times.
// [RULE13] Word transfer to data registers follows normal-mode timing.
// [RULE14] Last receive bit caught on the last falling edge before gating.
// [RULE15] Data-ready flag per word, or queue-full flag above watermark.
// [RULE16] Receive interrupt from ready or queue-full flag when enabled.
// [RULE17] Receive interrupt never coincides with the transmit interrupt.
// [RULE18] Host reads received data before the next word needs storing.
// [RULE19] Each falling receive clock edge shifts a bit into the shift register.
// [RULE20] Software enables the queue and sets the watermark before use.
// [RULE21] A word that cannot be stored sets the receive overrun flag.
module gcsp_port (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    // Control bits
    input  wire logic       unit_enable_bit,
    input  wire logic       tx_enable_bit,
    input  wire logic       rx_enable_bit,
    input  wire logic       clock_internal,
    input  wire logic       rx_queue_enable,
    input  wire logic [3:0] rx_queue_watermark,
    input  wire logic       rx_irq_enable,
    input  wire logic       tx_irq_enable,
    // Transmit data write
    input  wire logic       tx_write,
    input  wire logic [7:0] tx_data_reg,
    // Receive data read
    input  wire logic       rx_read,
    output logic [7:0]      rx_data_reg,
    // Status
    output logic            rx_data_ready_flag,
    output logic            rx_queue_full_flag,
    output logic            rx_overrun_flag,
    output logic            tx_empty_flag,
    output logic            rx_irq,
    output logic            tx_irq,
    // Serial pins
    input  wire logic       tx_bit_clock_in,
    output logic            tx_bit_clock_out,
    output logic            tx_bit_clock_oe,
    input  wire logic       serial_in_pin,
    output logic            serial_out_pin,
    output logic            serial_out_oe
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic sck_m;
    logic sck_s;
    logic sck_d;
    logic rxd_m;
    logic rxd_s;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sck_m <= 1'b0;
            sck_s <= 1'b0;
            sck_d <= 1'b0;
            rxd_m <= 1'b0;
            rxd_s <= 1'b0;
        end else begin
            sck_m <= tx_bit_clock_in;
            sck_s <= sck_m;
            sck_d <= sck_s;
            rxd_m <= serial_in_pin;
            rxd_s <= rxd_m;
        end
    end

    // ************************************************************
    // Mode decode
    // ************************************************************
    wire active   = unit_enable_bit && (tx_enable_bit || rx_enable_bit); // [RULE4]
    wire use_int  = clock_internal && tx_enable_bit; // [RULE4] [RULE3]
    wire ext_rise = !use_int && active && sck_s && !sck_d; // [RULE9]
    wire ext_fall = !use_int && active && !sck_s && sck_d; // [RULE9]

    // ************************************************************
    // Internal bit, word and frame counters
    // ************************************************************
    logic [7:0] div_cnt;
    logic       bit_phase;
    logic [2:0] bit_cnt_free;
    logic [1:0] slot_cnt;
    wire        div_tick   = (div_cnt == gcsp_pkg::HALF_BIT_CYCLES - 8'h01);
    wire        bit_end    = div_tick && bit_phase;
    wire        word_tick  = bit_end && (bit_cnt_free == gcsp_pkg::BIT_LAST);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt      <= 8'h00;
            bit_phase    <= 1'b0;
            bit_cnt_free <= 3'h0;
            slot_cnt     <= 2'h0;
        end else if (unit_enable_bit) begin
            div_cnt <= div_tick ? 8'h00 : div_cnt + 8'h01; // [RULE7]
            if (div_tick) begin
                bit_phase <= !bit_phase;
            end
            if (bit_end) begin
                bit_cnt_free <= bit_cnt_free + 3'h1;
            end
            if (word_tick) begin
                slot_cnt <= slot_cnt + 2'h1; // frame count kept, never used [RULE7]
            end
        end
    end

    // ************************************************************
    // Transmit holding register and internal clock gating
    // ************************************************************
    logic [7:0] tx_hold;
    logic       tx_full;
    logic       gate_on;
    logic       load_req;
    wire        start_word = use_int && active && word_tick && tx_full && !gate_on; // [RULE8]
    wire        next_word  = use_int && word_tick && gate_on && tx_full; // back to back
    wire        stop_word  = use_int && word_tick && gate_on && !tx_full; // [RULE2] [RULE12]
    wire        int_rise   = gate_on && div_tick && !bit_phase;
    wire        int_fall   = gate_on && bit_end;
    wire        sh_rise    = use_int ? int_rise : ext_rise; // [RULE3]
    wire        sh_fall    = use_int ? int_fall : ext_fall;
    logic [2:0] bit_cnt;
    wire        ext_load   = !use_int && tx_full && bit_cnt == 3'h0 && ext_rise;
    wire        take_tx    = start_word || next_word || ext_load;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_hold <= gcsp_pkg::WORD_RESET;
            tx_full <= 1'b0;
            gate_on <= 1'b0;
        end else begin
            if (tx_write) begin
                tx_hold <= tx_data_reg;
            end
            tx_full <= tx_write || (tx_full && !take_tx);
            if (start_word) begin
                gate_on <= 1'b1;
            end else if (stop_word || !use_int) begin
                gate_on <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Shift engine: out on rising edge, in on falling edge
    // ************************************************************
    logic [7:0] tx_shift;
    logic [7:0] rx_shift_reg;
    logic       word_done;
    wire        last_in = sh_fall && bit_cnt == gcsp_pkg::BIT_LAST; // [RULE14]
    assign load_req = take_tx;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_shift     <= gcsp_pkg::WORD_RESET;
            rx_shift_reg <= gcsp_pkg::WORD_RESET;
            bit_cnt      <= 3'h0;
            word_done    <= 1'b0;
        end else begin
            word_done <= 1'b0;
            if (load_req) begin
                tx_shift <= tx_hold;
            end else if (sh_rise && bit_cnt != 3'h0) begin
                tx_shift <= {tx_shift[6:0], 1'b0}; // [RULE11] [RULE6]
            end
            if (sh_fall && active) begin
                rx_shift_reg <= {rx_shift_reg[6:0], rxd_s}; // [RULE19] [RULE11]
                bit_cnt      <= bit_cnt + 3'h1;
                word_done    <= last_in && rx_enable_bit; // [RULE13]
            end
            if (!active) begin
                bit_cnt <= 3'h0;
            end
        end
    end

    // Drive the pins only while the unit transmits [RULE1]
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            serial_out_pin   <= 1'b0;
            serial_out_oe    <= 1'b0;
            tx_bit_clock_out <= 1'b0;
            tx_bit_clock_oe  <= 1'b0;
        end else begin
            serial_out_pin   <= tx_shift[7]; // [RULE5]
            serial_out_oe    <= active && tx_enable_bit;
            tx_bit_clock_out <= gate_on && !bit_phase ? 1'b0 : gate_on; // [RULE2]
            tx_bit_clock_oe  <= use_int && active;
        end
    end

    // ************************************************************
    // Receive path: skid buffer then data register or queue
    // ************************************************************
    logic       buf_valid;
    logic       buf_ready;
    logic [7:0] buf_data;
    logic       buf_in_ready;
    gcsp_buf2 u_buf (
        .clock     (clock),
        .arst_n    (arst_n),
        .in_valid  (word_done),
        .in_ready  (buf_in_ready),
        .in_data   (rx_shift_reg),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_data)
    );
    logic [3:0] level;
    wire        lost    = word_done && !buf_in_ready;
    wire        room    = rx_queue_enable ? (level != gcsp_pkg::LEVEL_FULL)
                                          : (level == gcsp_pkg::LEVEL_ZERO);
    wire        do_pop  = rx_read && level != gcsp_pkg::LEVEL_ZERO;
    assign buf_ready = room || do_pop;
    wire        do_push = buf_valid && buf_ready;
    // Circular queue kept as small register array
    logic [7:0] q_mem [0:7];
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    wire  [2:0] rd_next = do_pop ? rd_ptr + 3'h1 : rd_ptr;
    wire  [3:0] next_level = level + {3'h0, do_push} - {3'h0, do_pop};
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            level  <= gcsp_pkg::LEVEL_ZERO;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 3'h1;
            end
            rd_ptr <= rd_next;
            level  <= next_level;
        end
    end
    always_ff @(posedge clock) begin
        if (do_push) begin
            q_mem[wr_ptr] <= buf_data;
        end
    end

    // ************************************************************
    // Flags and interrupts
    // ************************************************************
    wire rx_event = rx_queue_enable ? (next_level > rx_queue_watermark)
                                    : (next_level != gcsp_pkg::LEVEL_ZERO); // [RULE15]
    wire rx_int_c = rx_irq_enable && rx_event; // [RULE16]
    wire tx_int_c = tx_irq_enable && !tx_full && !rx_int_c; // [RULE17]
    // Only a word the skid buffer cannot take is lost; a word parked there is not
    wire ovr_set  = lost; // [RULE21]
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rx_data_reg        <= gcsp_pkg::WORD_RESET;
            rx_data_ready_flag <= 1'b0;
            rx_queue_full_flag <= 1'b0;
            rx_overrun_flag    <= 1'b0;
            tx_empty_flag      <= 1'b0;
            rx_irq             <= 1'b0;
            tx_irq             <= 1'b0;
        end else begin
            rx_data_reg        <= (next_level != gcsp_pkg::LEVEL_ZERO) ? q_mem[rd_next]
                                                                       : rx_data_reg;
            rx_data_ready_flag <= !rx_queue_enable && rx_event; // [RULE15]
            rx_queue_full_flag <= rx_queue_enable && rx_event;
            rx_overrun_flag    <= ovr_set || (rx_overrun_flag && !rx_read); // set wins
            tx_empty_flag      <= !tx_full;
            rx_irq             <= rx_int_c; // [RULE16]
            tx_irq             <= tx_int_c; // [RULE17]
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_no_irq_clash;
        @(posedge clock) disable iff (!arst_n) !(rx_irq && tx_irq);
    endproperty
    a_no_irq_clash: assert property (p_no_irq_clash) else $error("irq clash"); // [RULE17]

    property p_idle_disabled;
        @(posedge clock) disable iff (!arst_n) !active |-> ##1 bit_cnt == 3'h0;
    endproperty
    a_idle_disabled: assert property (p_idle_disabled) else $error("idle moved"); // [RULE4]

    property p_rx_ovr;
        @(posedge clock) disable iff (!arst_n) ovr_set |=> rx_overrun_flag;
    endproperty
    a_rx_ovr: assert property (p_rx_ovr) else $error("overrun lost"); // [RULE21]

    property p_start_boundary;
        @(posedge clock) disable iff (!arst_n) $rose(gate_on) |-> $past(word_tick);
    endproperty
    a_start_boundary: assert property (p_start_boundary) else $error("start off slot"); // [RULE8]

    property p_stop_boundary;
        @(posedge clock) disable iff (!arst_n) $fell(gate_on) && use_int |-> $past(word_tick);
    endproperty
    a_stop_boundary: assert property (p_stop_boundary) else $error("stop off slot"); // [RULE12]

    sequence s_word_in;
        last_in && rx_enable_bit && active;
    endsequence
    property p_word_done;
        @(posedge clock) disable iff (!arst_n) s_word_in |=> word_done;
    endproperty
    a_word_done: assert property (p_word_done) else $error("word missed"); // [RULE14]

    property p_rx_irq;
        @(posedge clock) disable iff (!arst_n) rx_irq |-> rx_irq_enable || $past(rx_irq_enable);
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx irq unmasked"); // [RULE16]

    property p_shift_in;
        @(posedge clock) disable iff (!arst_n)
            sh_fall && active |=> rx_shift_reg[0] == $past(rxd_s);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("bit not taken"); // [RULE19]
endmodule
`default_nettype wire

// >>> hdl/gcsp_pkg.sv
`default_nettype none
package gcsp_pkg;
    // Word length in bits and counters used in gated clock mode
    localparam int unsigned WORD_BITS      = 8;
    localparam int unsigned SLOTS_PER_FRAME = 4;
    localparam int unsigned QUEUE_DEPTH    = 8;
    localparam int unsigned LEVEL_W        = 4;
    // Internal bit clock: half period in system clocks (40 MHz -> 1 MHz)
    localparam logic [7:0]  HALF_BIT_CYCLES = 8'h14;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [1:0]  SLOT_LAST      = 2'h3;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 8'h00;
    localparam logic [LEVEL_W-1:0]   LEVEL_ZERO = 4'h0;
    localparam logic [LEVEL_W-1:0]   LEVEL_ONE  = 4'h1;
    localparam logic [LEVEL_W-1:0]   LEVEL_FULL = 4'h8;
endpackage
`default_nettype wire

// >>> hdl/gcsp_buf2.sv
`timescale 1ns/100ps
`default_nettype none
// Two-entry skid buffer: a stalled drain loses no word until both entries are full
module gcsp_buf2 (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    // Fill side
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire logic [7:0] in_data,
    // Drain side
    output logic            out_valid,
    input  wire logic       out_ready,
    output logic [7:0]      out_data
);
    logic [7:0] slot0;
    logic [7:0] slot1;
    logic [1:0] count;
    wire        push = in_valid && in_ready;
    wire        pop  = out_valid && out_ready;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = slot0;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            slot0 <= 8'h00;
            slot1 <= 8'h00;
            count <= 2'h0;
        end else begin
            if (pop) begin
                slot0 <= (count == 2'h2) ? slot1 : in_data;
            end else if (push && count == 2'h0) begin
                slot0 <= in_data;
            end
            if (push && ((count == 2'h1 && !pop) || (count == 2'h2))) begin
                slot1 <= in_data;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// >>> dv/gcsp_far_end.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Far end: SPI-type peer on the bit clock
// ****************************************
module gcsp_far_end (
    // Resolved pin levels
    input  wire logic pin_clock,
    input  wire logic serial_out_pin,
    // Driven by the peer
    output logic      ext_clock,
    output logic      serial_in_pin
);
    logic [7:0] send_word;
    logic [7:0] got_word;
    logic [2:0] bit_idx;

    initial begin
        ext_clock = 1'b0;
        serial_in_pin = 1'b1;
        send_word = 8'h00;
        got_word = 8'h00;
        bit_idx = 3'h0;
    end

    task automatic arm(input logic [7:0] d);
        send_word = d;
        got_word = 8'h00;
        bit_idx = 3'h0;
    endtask

    // Clean 200 ns cycles, then the clock stands low
    task automatic clock_word();
        repeat (8) begin
            ext_clock = 1'b1;
            #100;
            ext_clock = 1'b0;
            #100;
        end
    endtask

    // New bit on the rise so it is settled at the capturing fall
    always @(posedge pin_clock) begin
        serial_in_pin <= send_word[3'h7 - bit_idx];
    end

    // The last bit is held half a bit past the final fall, since the unit sees
    // the pin through its synchroniser; then the line flips so a stale bit fails
    always @(negedge pin_clock) begin
        got_word <= {got_word[6:0], serial_out_pin};
        bit_idx <= bit_idx + 3'h1;
        if (bit_idx == 3'h7) begin
            serial_in_pin <= #100 ~send_word[0];
        end
    end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic       clock, arst_n, unit_enable_bit, tx_enable_bit, rx_enable_bit;
    logic       clock_internal, rx_queue_enable, rx_irq_enable, tx_irq_enable;
    logic       tx_write, rx_read, rx_data_ready_flag, rx_queue_full_flag;
    logic       rx_overrun_flag, tx_empty_flag, rx_irq, tx_irq, tx_bit_clock_out;
    logic       tx_bit_clock_oe, serial_out_pin, serial_out_oe, ext_clock;
    logic       link_clock, serial_in_pin, oe_seen;
    logic [3:0] rx_queue_watermark;
    logic [7:0] tx_data_reg, rx_data_reg;
    int         num_errors, total_checks, cyc, rises, n, c1, r0;

    gcsp_port uut (.clock, .arst_n, .unit_enable_bit, .tx_enable_bit, .rx_enable_bit,
        .clock_internal, .rx_queue_enable, .rx_queue_watermark, .rx_irq_enable,
        .tx_irq_enable, .tx_write, .tx_data_reg, .rx_read, .rx_data_reg,
        .rx_data_ready_flag, .rx_queue_full_flag, .rx_overrun_flag, .tx_empty_flag,
        .rx_irq, .tx_irq, .tx_bit_clock_in(link_clock), .tx_bit_clock_out,
        .tx_bit_clock_oe, .serial_in_pin, .serial_out_pin, .serial_out_oe);

    assign link_clock = tx_bit_clock_oe ? tx_bit_clock_out : ext_clock;

    gcsp_far_end far (.pin_clock(link_clock), .serial_out_pin, .ext_clock, .serial_in_pin);

    // ****************************************
    // Clock, monitors and helpers
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock) cyc++;

    // Outputs are looked at mid-cycle, where they have settled
    always @(negedge clock) begin
        if (tx_bit_clock_oe === 1'b1) oe_seen = 1'b1;
        if (rx_irq === 1'b1 && tx_irq === 1'b1) begin
            num_errors++;
            $display("CHECK FAILED t=%0t rx_irq=%h tx_irq=%h", $time, rx_irq, tx_irq);
        end
    end

    always @(posedge link_clock) rises++;

    task automatic end_sim();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return rx_data_ready_flag;
            1: return rx_queue_full_flag;
            2: return rx_overrun_flag;
            default: return tx_bit_clock_out;
        endcase
    endfunction

    // Bounded wait; running out ends the run
    task automatic wait_sig(input int s);
        for (n = 0; n < 2000 && pick(s) !== 1'b1; n++) @(negedge clock);
        if (n == 2000) begin
            num_errors++;
            $display("CHECK FAILED t=%0t wait=%h exp=%h", $time, s, 1);
            end_sim();
        end
    endtask

    task automatic mode(input logic te, input logic re, input logic ci, input logic qe);
        @(negedge clock);
        tx_enable_bit = te;
        rx_enable_bit = re;
        clock_internal = ci;
        rx_queue_enable = qe;
    endtask

    task automatic wr(input logic [7:0] d);
        @(negedge clock);
        tx_data_reg = d;
        tx_write = 1'b1;
        @(negedge clock);
        tx_write = 1'b0;
    endtask

    task automatic rd();
        @(negedge clock);
        rx_read = 1'b1;
        @(negedge clock);
        rx_read = 1'b0;
        repeat (4) @(negedge clock);
    endtask

    task automatic ext_word(input logic [7:0] d);
        far.arm(d);
        far.clock_word();
        repeat (8) @(negedge clock);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_idle();
        chk(rx_data_ready_flag | rx_overrun_flag | tx_bit_clock_oe, 8'h00);
        ext_word(8'h99);
        chk(rx_data_ready_flag, 8'h00);
        chk(serial_out_oe, 8'h00);
        // Both enables set but the unit switched off: nothing may move
        unit_enable_bit = 1'b0;
        mode(1'b1, 1'b1, 1'b0, 1'b0);
        ext_word(8'h66);
        chk({rx_data_ready_flag, serial_out_oe}, 8'h00);
        unit_enable_bit = 1'b1;
        $display("test idle done");
    endtask

    // An internal clock must not be made without transmit enabled
    task automatic t_rx_only();
        mode(1'b0, 1'b1, 1'b1, 1'b0);
        oe_seen = 1'b0;
        ext_word(8'hA5);
        wait_sig(0);
        repeat (3) @(negedge clock);
        chk(rx_data_reg, 8'hA5);
        chk(rx_irq, 8'h01);
        chk(oe_seen, 8'h00);
        rd();
        chk(rx_data_ready_flag, 8'h00);
        $display("test receive only done");
    endtask

    task automatic t_duplex();
        mode(1'b1, 1'b1, 1'b0, 1'b0);
        wr(8'h3C);
        ext_word(8'hC3);
        wait_sig(0);
        repeat (3) @(negedge clock);
        chk(rx_data_reg, 8'hC3);
        chk(far.got_word, 8'h3C);
        chk(tx_irq, 8'h00);
        rd();
        $display("test duplex external done");
    endtask

    task automatic t_tx_int();
        mode(1'b1, 1'b0, 1'b1, 1'b0);
        far.arm(8'h00);
        wr(8'h5A);
        wait_sig(3);
        c1 = cyc;
        repeat (310) @(negedge clock);
        chk(far.got_word, 8'h5A);
        chk(tx_empty_flag, 8'h01);
        chk(tx_irq, 8'h01);
        chk(tx_bit_clock_oe, 8'h01);
        chk(serial_out_oe, 8'h01);
        r0 = rises;
        repeat (200) @(negedge clock);
        chk(8'(rises - r0), 8'h00);
        far.arm(8'h00);
        wr(8'hA6);
        wait_sig(3);
        // Starts fall a whole number of word times apart
        chk(8'((cyc - c1) % (2 * gcsp_pkg::WORD_BITS * gcsp_pkg::HALF_BIT_CYCLES)),
            8'h00);
        repeat (310) @(negedge clock);
        chk(far.got_word, 8'hA6);
        $display("test transmit internal done");
    endtask

    task automatic t_overrun();
        mode(1'b0, 1'b1, 1'b0, 1'b0);
        rx_irq_enable = 1'b0;
        // Register plus the two buffer slots take three words with nothing lost
        for (int i = 0; i < 3; i++) ext_word(8'h10 + 8'(i));
        chk(rx_overrun_flag, 8'h00);
        for (int i = 3; i < 12; i++) ext_word(8'h10 + 8'(i));
        chk(rx_overrun_flag, 8'h01);
        chk(rx_irq, 8'h00);
        chk(rx_data_reg, 8'h10);
        rd();
        chk(rx_overrun_flag, 8'h00);
        for (int i = 1; i < 3; i++) begin
            chk(rx_data_reg, 8'h10 + 8'(i));
            rd();
        end
        chk(rx_data_ready_flag, 8'h00);
        rx_irq_enable = 1'b1;
        $display("test overrun done");
    endtask

    task automatic t_queue();
        mode(1'b0, 1'b1, 1'b0, 1'b1);
        ext_word(8'h21);
        ext_word(8'h22);
        chk(rx_queue_full_flag, 8'h00);
        ext_word(8'h23);
        wait_sig(1);
        chk(rx_irq, 8'h01);
        for (int i = 0; i < 3; i++) begin
            chk(rx_data_reg, 8'h21 + 8'(i));
            rd();
        end
        $display("test queue done");
    endtask

    initial begin
        {num_errors, total_checks, cyc, rises} = '0;
        {arst_n, tx_enable_bit, rx_enable_bit, clock_internal, rx_queue_enable} = '0;
        {tx_write, rx_read, oe_seen} = '0;
        unit_enable_bit = 1'b1;
        rx_irq_enable = 1'b1;
        tx_irq_enable = 1'b1;
        rx_queue_watermark = 4'h2;
        tx_data_reg = 8'h00;
        repeat (16) @(negedge clock);
        arst_n = 1'b1;
        repeat (2) @(negedge clock);
        t_idle();
        t_rx_only();
        t_duplex();
        t_tx_int();
        t_overrun();
        t_queue();
        end_sim();
    end
endmodule
`default_nettype wire
